// >>> axis_sync_regs.svh
/*
  Offsets, field positions, command codes, reset values and widths for the
  axis start-sync and interpolation preset block.
  Assumes byte addressing on a 32-bit AXI4-Lite bus, one aligned word per register.
*/
`ifndef AXIS_SYNC_REGS_SVH
`define AXIS_SYNC_REGS_SVH

// register byte offsets
`define OFS_MODE          8'h00
`define OFS_INTERP        8'h04
`define OFS_SCURVE        8'h08
`define OFS_HIGH_SPEED    8'h0c
`define OFS_LOW_SPEED     8'h10
`define OFS_COMMAND       8'h14
`define OFS_CONTROL       8'h18
`define OFS_STATUS        8'h1c
`define OFS_INTERP_WORK   8'h20
`define OFS_SCURVE_WORK   8'h24
`define OFS_MODE_WORK     8'h28

// operation mode preset fields
`define MODE_OPCODE_LSB   0
`define MODE_OPCODE_W     7
`define MODE_SCURVE_BIT   10
`define MODE_CPS_BIT      15
`define MODE_SYNC_LSB     18
`define MODE_MASK_LSB     20
`define MODE_CSTOP_IN_BIT 24
`define MODE_ESTOP_OUT_BIT 25
`define MODE_TSC_OFF_BIT  26
`define MODE_ARC_END_BIT  27
`define MODE_RDCNT_BIT    29

// start sync codes
`define SYNC_NOW          2'h0
`define SYNC_LINE         2'h1
`define SYNC_INTERNAL     2'h2
`define SYNC_AXES_STOP    2'h3

// operation codes
`define OP_LIN2_CONT      7'h62
`define OP_LIN2           7'h63
`define OP_ARC_CW         7'h64
`define OP_ARC_CCW        7'h65
`define OP_INTERP_GROUP   3'h6

// command codes
`define CMD_START         8'h50
`define CMD_RELEASE_A     8'h06
`define CMD_RELEASE_B     8'h2a

// widths and reset values
`define INTERP_W          28
`define SCURVE_W          15
`define SPEED_W           16
`define RESET_WORD        32'h0000_0000
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// >>> axis_sync_pkg.sv
/*
  Types shared by the axis start-sync block.
  Assumes nothing beyond the register header.
*/
package axis_sync_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_pending,
    st_running
  } axis_state_e;

  typedef logic [31:0] word_t;

endpackage

// >>> axil_slave.sv
/*
  Minimal AXI4-Lite slave front end: one write and one read at a time,
  address and data taken in either order, read data registered.
  Assumes the parent decodes addresses combinationally via wr_ok and rd_ok.
*/
`timescale 1ns/1ps
`include "axis_sync_regs.svh"

module axil_slave
  import axis_sync_pkg::*;
#(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // axi write channels
  input  wire logic [AW-1:0] s_awaddr,
  input  wire logic          s_awvalid,
  output logic               s_awready,
  input  wire logic [31:0]   s_wdata,
  input  wire logic [3:0]    s_wstrb,
  input  wire logic          s_wvalid,
  output logic               s_wready,
  output logic [1:0]         s_bresp,
  output logic               s_bvalid,
  input  wire logic          s_bready,
  // axi read channels
  input  wire logic [AW-1:0] s_araddr,
  input  wire logic          s_arvalid,
  output logic               s_arready,
  output logic [31:0]        s_rdata,
  output logic [1:0]         s_rresp,
  output logic               s_rvalid,
  input  wire logic          s_rready,
  // register side
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_ok,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_ok
);

  logic aw_held;
  logic w_held;

  assign s_awready = !aw_held;
  assign s_wready  = !w_held;
  assign s_arready = !s_rvalid;
  assign wr_en     = aw_held && w_held && !s_bvalid;
  assign rd_addr   = s_araddr;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= `RESET_WORD;
      wr_strb  <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= `RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
      end
      if (wr_en) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= `RESET_WORD;
      s_rresp  <= `RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_ok ? rd_data : `RESET_WORD;
      s_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

// >>> scurve_range_calc.sv
/*
  Effective S-curve acceleration range: the preset when non-zero, otherwise
  half the spread between the high and low speed presets. Result registered.
  Assumes speed presets are unsigned; a low speed above the high speed yields zero.
*/
`timescale 1ns/1ps
`include "axis_sync_regs.svh"

module scurve_range_calc #(
  parameter int RW = `SCURVE_W,
  parameter int SW = `SPEED_W
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // presets
  input  wire logic [RW-1:0] range_preset,
  input  wire logic [SW-1:0] high_speed,
  input  wire logic [SW-1:0] low_speed,
  // effective range
  output logic [RW-1:0]      range_eff
);

  logic [SW-1:0] spread;
  logic [RW-1:0] half_spread;
  logic [RW-1:0] next_range_eff;

  assign spread         = (high_speed > low_speed) ? SW'(high_speed - low_speed) : '0;
  assign half_spread    = RW'(spread >> 1);
  assign next_range_eff = (range_preset == '0) ? half_spread : range_preset;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      range_eff <= '0;
    end else begin
      range_eff <= next_range_eff;
    end
  end

endmodule

// >>> axis_start_sync.sv
/*
  Per-axis start synchronisation, coordinated stop and interpolation presets,
  with staged presets copied to working registers at the actual start.
  Assumes the motion core reports error stops and completion as one-cycle pulses,
  and that the coordinated lines are resolved as wired-AND outside.
*/
`timescale 1ns/1ps
`include "axis_sync_regs.svh"

// How it works
// - start code picks immediate, internal sync, axes-stop
// - code 01 waits line low or release
// - mask selects watched axes, all must stop
// - stop line halts axis when enabled
// - error stop drives shared stop line low
// - bit 26 zero enables top-speed correction
// - bit 27 draws arc to end point
// - bit 29 forces count method, else rule
// - interp parameter used only for 62h-65h
// - linear interpolation 2: master feed amount
// - circular: incremental arc centre
// - signed 28-bit parameter in low bits
// - S-curve range 1..32767 applied directly
// - zero range uses half speed spread
// - presets staged, working copies loaded at start
// - sign bits ignore writes, read field msb
// - scurve bits 15-31 ignore writes, read zero
module axis_start_sync
  import axis_sync_pkg::*;
#(
  parameter int AW     = 8,
  parameter int AXES   = 4
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rstn,
  // axi4-lite register bus
  input  wire logic [AW-1:0]   s_awaddr,
  input  wire logic            s_awvalid,
  output logic                 s_awready,
  input  wire logic [31:0]     s_wdata,
  input  wire logic [3:0]      s_wstrb,
  input  wire logic            s_wvalid,
  output logic                 s_wready,
  output logic [1:0]           s_bresp,
  output logic                 s_bvalid,
  input  wire logic            s_bready,
  input  wire logic [AW-1:0]   s_araddr,
  input  wire logic            s_arvalid,
  output logic                 s_arready,
  output logic [31:0]          s_rdata,
  output logic [1:0]           s_rresp,
  output logic                 s_rvalid,
  input  wire logic            s_rready,
  // coordination with other axes
  input  wire logic            coordinated_start_line_n,
  input  wire logic            coordinated_stop_line_n_in,
  output logic                 coordinated_stop_line_n_out,
  output logic                 coordinated_stop_line_n_oe,
  input  wire logic            internal_sync_start,
  input  wire logic [AXES-1:0] axis_stopped,
  // motion core
  input  wire logic            error_stop_event,
  input  wire logic            motion_done,
  output logic                 start_pulse,
  output logic                 axis_busy,
  output logic                 decel_stop_req,
  output logic                 immediate_stop_req,
  output logic                 top_speed_correction_en,
  output logic                 arc_endpoint_draw_en,
  output logic                 rampdown_count_method,
  output logic                 interp_is_feed,
  output logic                 interp_is_center,
  output logic [31:0]          interp_param_working,
  output logic [`SCURVE_W-1:0] scurve_accel_range_working,
  output logic [31:0]          mode_working
);

  function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] strb);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic word_t sext_interp(input logic [`INTERP_W-1:0] v);
    return {{(32-`INTERP_W){v[`INTERP_W-1]}}, v};
  endfunction

  // bus front end
  logic            wr_en;
  logic [AW-1:0]   wr_addr;
  logic [31:0]     wr_data;
  logic [3:0]      wr_strb;
  logic            wr_ok;
  logic [AW-1:0]   rd_addr;
  logic [31:0]     rd_data;
  logic            rd_ok;

  axil_slave #(.AW(AW)) u_bus (
    .clk       (clk),
    .rstn      (rstn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  // staged presets and control
  word_t                   operation_mode_preset;
  logic [`INTERP_W-1:0]    interp_center_or_feed_preset;
  logic [`SCURVE_W-1:0]    scurve_accel_range_preset;
  logic [`SPEED_W-1:0]     high_speed_preset;
  logic [`SPEED_W-1:0]     low_speed_preset;
  logic                    stop_immediate;
  axis_state_e             state;
  axis_state_e             next_state;
  logic                    error_stop_active;
  logic                    last_stop_coord;
  logic                    cond_met;

  // write decode
  wire w_mode    = wr_en && (wr_addr == `OFS_MODE);
  wire w_interp  = wr_en && (wr_addr == `OFS_INTERP);
  wire w_scurve  = wr_en && (wr_addr == `OFS_SCURVE);
  wire w_high    = wr_en && (wr_addr == `OFS_HIGH_SPEED);
  wire w_low     = wr_en && (wr_addr == `OFS_LOW_SPEED);
  wire w_command = wr_en && (wr_addr == `OFS_COMMAND) && wr_strb[0];
  wire w_control = wr_en && (wr_addr == `OFS_CONTROL);

  assign wr_ok = (wr_addr == `OFS_MODE) || (wr_addr == `OFS_INTERP) || (wr_addr == `OFS_SCURVE) ||
                 (wr_addr == `OFS_HIGH_SPEED) || (wr_addr == `OFS_LOW_SPEED) ||
                 (wr_addr == `OFS_COMMAND) || (wr_addr == `OFS_CONTROL);

  wire cmd_start   = w_command && (wr_data[7:0] == `CMD_START);
  wire cmd_release = w_command && ((wr_data[7:0] == `CMD_RELEASE_A) || (wr_data[7:0] == `CMD_RELEASE_B));

  word_t merged;
  assign merged = merge(`RESET_WORD, wr_data, wr_strb);

  // sign-extension bits and unused upper bits are simply not stored
  word_t interp_merge;
  word_t scurve_merge;
  assign interp_merge = merge(sext_interp(interp_center_or_feed_preset), wr_data, wr_strb);
  assign scurve_merge = merge({{(32-`SCURVE_W){1'b0}}, scurve_accel_range_preset}, wr_data, wr_strb);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      operation_mode_preset        <= `RESET_WORD;
      interp_center_or_feed_preset <= '0;
      scurve_accel_range_preset    <= '0;
      high_speed_preset            <= '0;
      low_speed_preset             <= '0;
      stop_immediate               <= 1'b0;
    end else begin
      if (w_mode) operation_mode_preset <= merge(operation_mode_preset, wr_data, wr_strb);
      if (w_interp) interp_center_or_feed_preset <= interp_merge[`INTERP_W-1:0];
      if (w_scurve) scurve_accel_range_preset <= scurve_merge[`SCURVE_W-1:0];
      if (w_high) high_speed_preset <= 16'(merge({16'h0000, high_speed_preset}, wr_data, wr_strb));
      if (w_low) low_speed_preset <= merged[`SPEED_W-1:0] | (low_speed_preset & ~{{8{wr_strb[1]}}, {8{wr_strb[0]}}});
      if (w_control && wr_strb[0]) stop_immediate <= wr_data[0];
    end
  end

  // start condition, registered so the launch falls in the cycle after it holds
  wire [1:0]      sync_sel  = operation_mode_preset[`MODE_SYNC_LSB +: 2];
  wire [AXES-1:0] watch     = operation_mode_preset[`MODE_MASK_LSB +: AXES];
  wire            axes_done = ((axis_stopped & watch) == watch);
  wire            cond_now  = (sync_sel == `SYNC_NOW) ||
                              ((sync_sel == `SYNC_LINE) && (!coordinated_start_line_n || cmd_release)) ||
                              ((sync_sel == `SYNC_INTERNAL) && internal_sync_start) ||
                              ((sync_sel == `SYNC_AXES_STOP) && axes_done);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cond_met <= 1'b0;
    end else begin
      cond_met <= cond_now;
    end
  end

  // effective scurve range
  logic [`SCURVE_W-1:0] scurve_eff;

  scurve_range_calc #(.RW(`SCURVE_W), .SW(`SPEED_W)) u_scurve (
    .clk          (clk),
    .rstn         (rstn),
    .range_preset (scurve_accel_range_preset),
    .high_speed   (high_speed_preset),
    .low_speed    (low_speed_preset),
    .range_eff    (scurve_eff)
  );

  // axis sequencing
  wire launch     = (state == st_pending) && cond_met && !cmd_start;
  wire coord_stop = (state == st_running) && mode_working[`MODE_CSTOP_IN_BIT] &&
                    !coordinated_stop_line_n_in;
  wire err_stop   = (state == st_running) && error_stop_event;

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (cmd_start) next_state = st_pending;
      end
      st_pending: begin
        if (launch) next_state = st_running;
      end
      st_running: begin
        if (coord_stop || err_stop || motion_done) next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state                      <= st_idle;
      mode_working               <= `RESET_WORD;
      interp_param_working       <= `RESET_WORD;
      scurve_accel_range_working <= '0;
      decel_stop_req             <= 1'b0;
      immediate_stop_req         <= 1'b0;
      error_stop_active          <= 1'b0;
      last_stop_coord            <= 1'b0;
    end else begin
      state              <= next_state;
      decel_stop_req     <= coord_stop && !stop_immediate;
      immediate_stop_req <= coord_stop && stop_immediate;
      if (launch) begin
        mode_working               <= operation_mode_preset;
        interp_param_working       <= sext_interp(interp_center_or_feed_preset);
        scurve_accel_range_working <= scurve_eff;
      end
      if (err_stop && mode_working[`MODE_ESTOP_OUT_BIT]) begin
        error_stop_active <= 1'b1;
      end else if (cmd_start) begin
        error_stop_active <= 1'b0;
      end
      if (coord_stop) begin
        last_stop_coord <= 1'b1;
      end else if (cmd_start) begin
        last_stop_coord <= 1'b0;
      end
    end
  end

  assign start_pulse = launch;
  assign axis_busy   = (state != st_idle);

  // open-drain shared stop line, pulled low only on an error stop
  assign coordinated_stop_line_n_out = 1'b0;
  assign coordinated_stop_line_n_oe  = error_stop_active;

  // mode decode from the working copy
  wire [6:0] op_code   = mode_working[`MODE_OPCODE_LSB +: `MODE_OPCODE_W];
  wire       op_interp = (op_code[6:4] == `OP_INTERP_GROUP);

  assign top_speed_correction_en = !mode_working[`MODE_TSC_OFF_BIT];
  assign interp_is_feed          = (op_code == `OP_LIN2_CONT) || (op_code == `OP_LIN2);
  assign interp_is_center        = (op_code == `OP_ARC_CW) || (op_code == `OP_ARC_CCW);
  assign arc_endpoint_draw_en    = interp_is_center && mode_working[`MODE_ARC_END_BIT];
  assign rampdown_count_method   = mode_working[`MODE_RDCNT_BIT] ||
                                   (op_interp && mode_working[`MODE_CPS_BIT]);

  // read decode
  wire [31:0] status_word = {27'h0, last_stop_coord, !coordinated_stop_line_n_in, error_stop_active,
                             state == st_running, state == st_pending};

  assign rd_ok = (rd_addr == `OFS_MODE) || (rd_addr == `OFS_INTERP) || (rd_addr == `OFS_SCURVE) ||
                 (rd_addr == `OFS_HIGH_SPEED) || (rd_addr == `OFS_LOW_SPEED) ||
                 (rd_addr == `OFS_COMMAND) || (rd_addr == `OFS_CONTROL) || (rd_addr == `OFS_STATUS) ||
                 (rd_addr == `OFS_INTERP_WORK) || (rd_addr == `OFS_SCURVE_WORK) ||
                 (rd_addr == `OFS_MODE_WORK);

  assign rd_data = (rd_addr == `OFS_MODE)        ? operation_mode_preset :
                   (rd_addr == `OFS_INTERP)      ? sext_interp(interp_center_or_feed_preset) :
                   (rd_addr == `OFS_SCURVE)      ? {17'h0, scurve_accel_range_preset} :
                   (rd_addr == `OFS_HIGH_SPEED)  ? {16'h0, high_speed_preset} :
                   (rd_addr == `OFS_LOW_SPEED)   ? {16'h0, low_speed_preset} :
                   (rd_addr == `OFS_CONTROL)     ? {31'h0, stop_immediate} :
                   (rd_addr == `OFS_STATUS)      ? status_word :
                   (rd_addr == `OFS_INTERP_WORK) ? interp_param_working :
                   (rd_addr == `OFS_SCURVE_WORK) ? {17'h0, scurve_accel_range_working} :
                   (rd_addr == `OFS_MODE_WORK)   ? mode_working :
                   `RESET_WORD;

endmodule

// >>> axis_start_sync_asserts.sv
/*
  Checker for the port relations of axis_start_sync.
  Assumes it is bound to the top module: one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module axis_start_sync_asserts (
  // watched ports
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        coordinated_stop_line_n_out,
  input  wire logic        coordinated_stop_line_n_oe,
  input  wire logic        error_stop_event,
  input  wire logic        start_pulse,
  input  wire logic        axis_busy,
  input  wire logic        top_speed_correction_en,
  input  wire logic        arc_endpoint_draw_en,
  input  wire logic        rampdown_count_method,
  input  wire logic        interp_is_feed,
  input  wire logic        interp_is_center,
  input  wire logic [31:0] interp_param_working,
  input  wire logic [31:0] mode_working
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic [6:0] op = mode_working[6:0];
  wire logic [3:0] sx = {4{interp_param_working[27]}};
  sequence s_launch;
    start_pulse ##1 (axis_busy && !start_pulse);
  endsequence
  a_tsc_polarity: assert property (top_speed_correction_en == !mode_working[26])
    else $error("top speed correction enable wrong");
  a_rampdown_method: assert property (
    rampdown_count_method == (mode_working[29] || (op[6:4] == 3'h6 && mode_working[15])))
    else $error("ramp-down method wrong");
  a_feed_decode: assert property (interp_is_feed == (op == 7'h62 || op == 7'h63))
    else $error("feed decode wrong");
  a_center_decode: assert property (interp_is_center == (op == 7'h64 || op == 7'h65))
    else $error("centre decode wrong");
  a_arc_draw: assert property (arc_endpoint_draw_en == (interp_is_center && mode_working[27]))
    else $error("arc end draw wrong");
  a_sign_copy: assert property (interp_param_working[31:28] == sx)
    else $error("interp sign bits wrong");
  a_start_launch: assert property (start_pulse |-> s_launch)
    else $error("launch not followed by run");
  a_stop_raise: assert property ($rose(coordinated_stop_line_n_oe) |->
    $past(error_stop_event) && $past(mode_working[25]))
    else $error("stop line driven without cause");
  a_stop_drive: assert property (coordinated_stop_line_n_oe |-> !coordinated_stop_line_n_out)
    else $error("stop line not pulled low");
endmodule

bind axis_start_sync axis_start_sync_asserts i_axis_start_sync_asserts (.*);

// >>> axis_peer_model.sv
/*
  Partner model: the other axes and the shared start and stop lines.
  Assumes pull-ups on both shared lines; requests come from the bench.
*/
`timescale 1ns/1ps
module axis_peer_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // requests from the bench
  input  wire logic       peer_start,
  input  wire logic       peer_stop,
  input  wire logic       peer_sync,
  input  wire logic [3:0] peer_stopped,
  // design drive of the stop line
  input  wire logic       coordinated_stop_line_n_oe,
  input  wire logic       coordinated_stop_line_n_out,
  // lines seen by the design
  output logic            coordinated_start_line_n,
  output logic            coordinated_stop_line_n_in,
  output logic            internal_sync_start,
  output logic [3:0]      axis_stopped
);
  logic sync_q;
  wire logic dut_pull = coordinated_stop_line_n_oe && !coordinated_stop_line_n_out;
  // released lines return to the pull-up level
  assign coordinated_start_line_n = !peer_start;
  assign coordinated_stop_line_n_in = !(peer_stop || dut_pull);
  assign internal_sync_start = peer_sync && !sync_q;
  assign axis_stopped = peer_stopped;
  always_ff @(posedge clk) begin
    sync_q <= rstn && peer_sync;
  end
endmodule

// >>> axis_start_sync_test.sv
/*
  Testbench for axis_start_sync: AXI4-Lite tasks and preset scenarios.
  Assumes the peer model on the coordination lines; the bench plays the motion core.
*/
`timescale 1ns/1ps
`include "axis_sync_regs.svh"
module axis_start_sync_test;
  logic        clk = 0, rstn = 0;
  logic [7:0]  s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0;
  logic [3:0]  s_wstrb = 0, peer_stopped = 0;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        peer_start = 0, peer_stop = 0, peer_sync = 0, error_stop_event = 0, motion_done = 0;
  wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, start_pulse, axis_busy;
  wire         decel_stop_req, immediate_stop_req, top_speed_correction_en, arc_endpoint_draw_en;
  wire         rampdown_count_method, interp_is_feed, interp_is_center, internal_sync_start;
  wire         coordinated_start_line_n, coordinated_stop_line_n_in;
  wire         coordinated_stop_line_n_out, coordinated_stop_line_n_oe;
  wire [1:0]   s_bresp, s_rresp;
  wire [3:0]   axis_stopped;
  wire [14:0]  scurve_accel_range_working;
  wire [31:0]  s_rdata, interp_param_working, mode_working;
  int          failures = 0, n_checks = 0, n_start = 0, n_dec = 0, n_imm = 0, cyc = 0;
  logic [31:0] modes [8] = '{32'h0400_8461, 32'h0004_0062, 32'h2004_0063, 32'h0804_0064,
                             32'h0008_0065, 32'h001c_8000, 32'h00cc_0000, 32'h00fc_0000};
  logic [3:0]  pre [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'he, 4'h7, 4'he};

  axis_start_sync i_axis_start_sync (.*);
  axis_peer_model i_axis_peer_model (.*);

  always #10 clk = ~clk;

  task conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // pulses are counted mid-cycle, where they have settled
  always @(negedge clk) begin
    if (start_pulse === 1'b1) n_start++;
    if (decel_stop_req === 1'b1) n_dec++;
    if (immediate_stop_req === 1'b1) n_imm++;
    cyc++;
    if (cyc > 20000) begin
      failures++;
      conclude();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // readiness seen mid-cycle holds at the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hf, input logic [1:0] er = 0);
    logic pa, pw, pb;
    {pa, pw, pb} = 3'h7;
    {s_awaddr, s_wdata, s_wstrb} <= {a, d, st};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    repeat (40) if (pb) begin
      @(negedge clk);
      if (s_awready === 1'b1) pa = 0;
      if (s_wready === 1'b1) pw = 0;
      if (s_bvalid === 1'b1) begin
        pb = 0;
        chk("bresp", 32'(er), 32'(s_bresp));
      end
      @(posedge clk);
      {s_awvalid, s_wvalid, s_bready} <= {pa, pw, pb};
    end
    if (pb) chk("bvalid", 1, 0);
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 0);
    logic pa, pr;
    {pa, pr} = 2'h3;
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    repeat (40) if (pr) begin
      @(negedge clk);
      if (s_arready === 1'b1) pa = 0;
      if (s_rvalid === 1'b1) begin
        pr = 0;
        chk("rdata", e, s_rdata);
        chk("rresp", 32'(er), 32'(s_rresp));
      end
      @(posedge clk);
      {s_arvalid, s_rready} <= {pa, pr};
    end
    if (pr) chk("rvalid", 1, 0);
    @(posedge clk);
  endtask

  task go;
    wr(`OFS_COMMAND, 32'h50);
  endtask

  task end_move;
    motion_done <= 1;
    @(posedge clk);
    motion_done <= 0;
    @(posedge clk);
  endtask

  initial begin
    int i, b, c;
    logic [31:0] m;
    logic [6:0] op;
    logic ctr;
    logic [4:0] e5;
    tick(2);
    rstn <= 1;
    @(posedge clk);
    rd(`OFS_MODE, 0);
    rd(`OFS_INTERP, 0);
    rd(`OFS_SCURVE, 0);
    wr(`OFS_SCURVE, 32'hffff_ffff);
    rd(`OFS_SCURVE, 32'h0000_7fff);
    wr(`OFS_INTERP, 32'hf000_0000);
    rd(`OFS_INTERP, 0);
    wr(`OFS_INTERP, 32'h0800_0001);
    rd(`OFS_INTERP, 32'hf800_0001);
    wr(`OFS_MODE, 32'hffff_ffff, 4'h1);
    rd(`OFS_MODE, 32'h0000_00ff);
    wr(8'h40, 32'h1, 4'hf, 2'h2);
    rd(8'h40, 0, 2'h2);
    wr(`OFS_SCURVE, 0);
    wr(`OFS_HIGH_SPEED, 100);
    wr(`OFS_LOW_SPEED, 40);
    wr(`OFS_MODE, 0);
    go;
    tick(2);
    chk("scurve_w", 30, 32'(scurve_accel_range_working));
    wr(`OFS_INTERP, 5);
    wr(`OFS_SCURVE, 32767);
    chk("interp_w", 32'hf800_0001, interp_param_working);
    end_move;
    go;
    tick(2);
    chk("scurve_w", 32767, 32'(scurve_accel_range_working));
    chk("interp_w", 5, interp_param_working);
    end_move;
    for (i = 0; i < 8; i++) begin
      m = modes[i];
      peer_stopped <= pre[i];
      wr(`OFS_MODE, m);
      b = n_start;
      go;
      tick(4);
      chk("start_held", 32'(i == 0), 32'(n_start - b));
      case (i)
        1: peer_start <= 1;
        2: wr(`OFS_COMMAND, 32'h06);
        3: wr(`OFS_COMMAND, 32'h2a);
        4: peer_sync <= 1;
        default: peer_stopped <= 4'hf;
      endcase
      tick(3);
      chk("start_count", 1, 32'(n_start - b));
      chk("mode_w", m, mode_working);
      op = m[6:0];
      ctr = (op == 7'h64 || op == 7'h65);
      e5 = {op == 7'h62 || op == 7'h63, ctr, ctr & m[27], !m[26], m[29] | (op[6:4] == 3'h6 & m[15])};
      chk("decode", 32'(e5), 32'({interp_is_feed, interp_is_center, arc_endpoint_draw_en,
        top_speed_correction_en, rampdown_count_method}));
      peer_start <= 0;
      peer_sync <= 0;
      end_move;
    end
    for (i = 0; i < 3; i++) begin
      wr(`OFS_CONTROL, 32'(i & 1));
      wr(`OFS_MODE, (i < 2) ? 32'h0100_0000 : 32'h0);
      go;
      tick(2);
      b = n_dec;
      c = n_imm;
      peer_stop <= 1;
      tick(4);
      peer_stop <= 0;
      chk("decel_req", 32'(i == 0), 32'(n_dec - b));
      chk("immed_req", 32'(i == 1), 32'(n_imm - c));
      if (i == 2) end_move;
    end
    wr(`OFS_MODE, 32'h0200_0000);
    go;
    tick(2);
    error_stop_event <= 1;
    @(posedge clk);
    error_stop_event <= 0;
    tick(2);
    chk("stop_oe", 1, 32'(coordinated_stop_line_n_oe));
    chk("stop_line", 0, 32'(coordinated_stop_line_n_in));
    go;
    tick(2);
    chk("stop_oe", 0, 32'(coordinated_stop_line_n_oe));
    end_move;
    conclude();
  end
endmodule
